// [hw/sca_rtt.sv]
/*
 * seconds counter with alarm: apb register slave, 32-bit counter, alarm compare,
 * read-cleared event flags and a gated interrupt output.
 * assumes an apb master on clk_sys_i and a 10 MHz clock; the slow clock is an enable.
 */
`timescale 1ns/1ps

// Operation
// - a 32-bit counter advances once per prescaler period of the slow clock
// - divisor zero gives 65536 slow cycles, otherwise the divisor itself
// - divisor 32768 with a 32768 Hz slow clock advances once per second
// - the counter wraps from all ones to zero and keeps counting
// - the alarm register resets to all ones
// - an advance while count equals alarm sets the match flag
// - every counter advance sets the tick flag
// - reading the status register clears both flags
// - flags clear two slow clock periods after the status read
// - mode bit 16 gates the match flag onto the interrupt
// - mode bit 17 gates the tick flag onto the interrupt
// - writing restart bit 18 reloads the prescaler and zeroes the counter
// - status bit 0 is the match flag, bit 1 the tick flag, rest zero
module sca_rtt
    import sca_pkg::*;
#(
    parameter int unsigned SLOW_DIV_P = SLOW_DIV
) (
    input  wire logic              clk_sys_i,
    input  wire logic              rst_i,
    input  wire logic              psel_i,
    input  wire logic              penable_i,
    input  wire logic              pwrite_i,
    input  wire logic [APB_AW-1:0] paddr_i,
    input  wire logic [31:0]       pwdata_i,
    output logic      [31:0]       prdata_o,
    output logic                   pready_o,
    output logic                   pslverr_o,
    output logic                   irq_o
);
    sca_mode_t       mode_q;
    sca_flags_t      flags_q;
    sca_clr_state_t  clr_state_q;
    logic [31:0]     alarm_q;
    logic [31:0]     count_q;
    logic [1:0]      clr_cnt_q;
    logic            restart_q;
    logic            slow_tick;
    logic            inc;
    logic            done;
    logic            wr_mode;
    logic            wr_alarm;
    logic            rd_flags;
    logic            mapped;
    logic            match_set;
    logic            clr_fire;
    logic [31:0]     rd_word;

    // ---------------- apb slave: one wait state, answer in second access cycle
    assign done     = psel_i && penable_i && pready_o;
    assign mapped   = (paddr_i == OFS_MODE) || (paddr_i == OFS_ALARM) ||
                      (paddr_i == OFS_COUNT) || (paddr_i == OFS_FLAGS);
    assign wr_mode  = done && pwrite_i && (paddr_i == OFS_MODE);
    assign wr_alarm = done && pwrite_i && (paddr_i == OFS_ALARM);
    assign rd_flags = done && !pwrite_i && (paddr_i == OFS_FLAGS);

    always_comb begin
        rd_word = 32'h0;
        case (paddr_i)
            OFS_MODE: begin
                rd_word = mode_q;
                rd_word[POS_RESTART] = 1'b0;
            end
            OFS_ALARM: begin
                rd_word = alarm_q;
            end
            OFS_COUNT: begin
                rd_word = count_q;
            end
            OFS_FLAGS: begin
                rd_word = {30'h0, flags_q.tick_flag, flags_q.match_flag};
            end
            default: begin
                rd_word = 32'h0;
            end
        endcase
    end

    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            pready_o  <= 1'b0;
            pslverr_o <= 1'b0;
            prdata_o  <= 32'h0;
        end else if (psel_i && penable_i && !pready_o) begin
            pready_o  <= 1'b1;
            pslverr_o <= !mapped;
            prdata_o  <= (pwrite_i || !mapped) ? 32'h0 : rd_word;
        end else begin
            pready_o  <= 1'b0;
            pslverr_o <= 1'b0;
            prdata_o  <= 32'h0;
        end
    end

    // ---------------- control registers
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            mode_q    <= MODE_RESET;
            restart_q <= 1'b0;
        end else begin
            restart_q <= wr_mode && pwdata_i[POS_RESTART];
            if (wr_mode) begin
                mode_q                 <= pwdata_i;
                mode_q.divider_restart <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            alarm_q <= ALARM_RESET;
        end else if (wr_alarm) begin
            alarm_q <= pwdata_i;
        end
    end

    // ---------------- prescaler and counter
    sca_prescaler #(
        .SLOW_DIV_P (SLOW_DIV_P)
    ) u_prescaler (
        .clk_sys_i   (clk_sys_i),
        .rst_i       (rst_i),
        .restart_i   (restart_q),
        .divisor_i   (mode_q.prescale_divisor),
        .slow_tick_o (slow_tick),
        .inc_o       (inc)
    );

    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            count_q <= COUNT_RESET;
        end else if (restart_q) begin
            count_q <= COUNT_RESET;
        end else if (inc) begin
            count_q <= count_q + 32'h1;
        end
    end

    // match taken on the advance out of the alarm value, i.e. count reaching alarm+1
    assign match_set = inc && !restart_q && (count_q == alarm_q);

    // ---------------- delayed read clear, counted in slow clock periods
    assign clr_fire = (clr_state_q == CLR_WAIT) && slow_tick &&
                      (clr_cnt_q == CLR_DELAY_SLOW - 2'h1);

    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            clr_state_q <= CLR_IDLE;
            clr_cnt_q   <= 2'h0;
        end else begin
            case (clr_state_q)
                CLR_IDLE: begin
                    if (rd_flags) begin
                        clr_state_q <= CLR_WAIT;
                        clr_cnt_q   <= 2'h0;
                    end
                end
                CLR_WAIT: begin
                    if (clr_fire) begin
                        clr_state_q <= CLR_IDLE;
                        clr_cnt_q   <= 2'h0;
                    end else if (slow_tick) begin
                        clr_cnt_q <= clr_cnt_q + 2'h1;
                    end
                end
                default: begin
                    clr_state_q <= CLR_IDLE;
                    clr_cnt_q   <= 2'h0;
                end
            endcase
        end
    end

    // a set in the clearing cycle wins
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            flags_q <= '0;
        end else begin
            flags_q.unused <= '0;
            if (inc && !restart_q) begin
                flags_q.tick_flag <= 1'b1;
            end else if (clr_fire) begin
                flags_q.tick_flag <= 1'b0;
            end
            if (match_set) begin
                flags_q.match_flag <= 1'b1;
            end else if (clr_fire) begin
                flags_q.match_flag <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            irq_o <= 1'b0;
        end else begin
            irq_o <= (flags_q.match_flag && mode_q.match_irq_enable) ||
                     (flags_q.tick_flag && mode_q.tick_irq_enable);
        end
    end

    // ---------------- checks
    logic first_q;

    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            first_q <= 1'b1;
        end else begin
            first_q <= 1'b0;
        end
    end

    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (rst_i);

    sequence s_flags_read;
        rd_flags ##1 (clr_state_q == CLR_WAIT);
    endsequence

    sequence s_clear_no_set;
        clr_fire && !inc && !match_set;
    endsequence

    sequence s_restart_write;
        wr_mode && pwdata_i[POS_RESTART];
    endsequence

    count_adv_a: assert property (
        (inc && !restart_q) |=> count_q == $past(count_q) + 32'h1)
        else $error("counter did not advance on an increment");
    count_hold_a: assert property (
        (!inc && !restart_q) |=> $stable(count_q))
        else $error("counter moved without an increment");
    count_wrap_a: assert property (
        (inc && !restart_q && count_q == COUNT_MAX) |=> count_q == COUNT_RESET)
        else $error("counter did not wrap to zero");
    alarm_reset_a: assert property (
        first_q |-> alarm_q == ALARM_RESET)
        else $error("alarm not all ones after reset");
    match_set_a: assert property (
        match_set |=> flags_q.match_flag && count_q == $past(alarm_q) + 32'h1)
        else $error("match flag not set on alarm match");
    tick_set_a: assert property (
        (inc && !restart_q) |=> flags_q.tick_flag)
        else $error("tick flag not set on increment");
    read_arms_a: assert property (
        (rd_flags && clr_state_q == CLR_IDLE) |-> s_flags_read)
        else $error("status read did not arm the clear");
    flag_clear_a: assert property (
        s_clear_no_set |=> !flags_q.tick_flag && !flags_q.match_flag)
        else $error("flags not cleared after two slow periods");
    clear_wait_a: assert property (
        (clr_state_q == CLR_WAIT && slow_tick && clr_cnt_q == 2'h0) |=>
            (clr_state_q == CLR_WAIT) && (clr_cnt_q == 2'h1) &&
            (flags_q.tick_flag || !$past(flags_q.tick_flag)) &&
            (flags_q.match_flag || !$past(flags_q.match_flag)))
        else $error("flags cleared before the second slow period");
    irq_mask_a: assert property (
        (!mode_q.match_irq_enable && !mode_q.tick_irq_enable)[*2] |-> !irq_o)
        else $error("interrupt raised while both sources masked");
    irq_match_a: assert property (
        (flags_q.match_flag && mode_q.match_irq_enable) |=> irq_o)
        else $error("enabled match flag did not raise the interrupt");
    irq_tick_a: assert property (
        (flags_q.tick_flag && mode_q.tick_irq_enable) |=> irq_o)
        else $error("enabled tick flag did not raise the interrupt");
    tick_hold_a: assert property (
        (flags_q.tick_flag && !clr_fire) |=> flags_q.tick_flag)
        else $error("tick flag lost without a status read");
    match_hold_a: assert property (
        (flags_q.match_flag && !clr_fire) |=> flags_q.match_flag)
        else $error("match flag lost without a status read");
    match_quiet_a: assert property (
        (!flags_q.match_flag && !match_set) |=> !flags_q.match_flag)
        else $error("match flag set without an alarm match");
    tick_quiet_a: assert property (
        (!flags_q.tick_flag && !(inc && !restart_q)) |=> !flags_q.tick_flag)
        else $error("tick flag set without an increment");
    ready_pulse_a: assert property (
        pready_o |=> !pready_o)
        else $error("ready stood longer than one cycle");
    restart_zero_a: assert property (
        s_restart_write |=> restart_q ##1 count_q == COUNT_RESET)
        else $error("restart did not zero the counter");
    status_bits_a: assert property (
        (pready_o && !pwrite_i && paddr_i == OFS_FLAGS) |->
            prdata_o[31:2] == 30'h0 && prdata_o[POS_TICK_FLAG] == $past(flags_q.tick_flag) &&
            prdata_o[POS_MATCH_FLAG] == $past(flags_q.match_flag))
        else $error("status word layout wrong");
    restart_read_a: assert property (
        (pready_o && paddr_i == OFS_MODE) |-> !prdata_o[POS_RESTART])
        else $error("restart bit read back as one");

endmodule // sca_rtt

// [hw/sca_pkg.sv]
/*
 * shared constants and types of the seconds counter with alarm: register
 * offsets, reset values, field positions, timing figures and register layouts.
 * assumes a single 10 MHz system clock; the slow clock is an enable derived from it.
 */
package sca_pkg;

    // system clock and nominal slow clock rates
    localparam int unsigned SYS_CLK_HZ      = 10_000_000;
    localparam int unsigned SLOW_CLK_HZ     = 32_768;
    // system cycles per slow clock period, rounded down
    localparam int unsigned SLOW_DIV        = SYS_CLK_HZ / SLOW_CLK_HZ;

    localparam int unsigned APB_AW          = 12;
    localparam logic [11:0] OFS_MODE        = 12'h000;
    localparam logic [11:0] OFS_ALARM       = 12'h004;
    localparam logic [11:0] OFS_COUNT       = 12'h008;
    localparam logic [11:0] OFS_FLAGS       = 12'h00c;

    localparam logic [31:0] MODE_RESET      = 32'h0000_8000;
    localparam logic [31:0] ALARM_RESET     = 32'hffff_ffff;
    localparam logic [31:0] COUNT_RESET     = 32'h0000_0000;
    localparam logic [31:0] COUNT_MAX       = 32'hffff_ffff;
    localparam logic [15:0] PRE_RESET       = 16'h7fff;

    localparam int unsigned POS_MATCH_IEN   = 16;
    localparam int unsigned POS_TICK_IEN    = 17;
    localparam int unsigned POS_RESTART     = 18;
    localparam int unsigned POS_MATCH_FLAG  = 0;
    localparam int unsigned POS_TICK_FLAG   = 1;

    // slow clock periods between a status read and the flag clear
    localparam logic [1:0]  CLR_DELAY_SLOW  = 2'h2;

    typedef struct packed {
        logic [12:0] unused;
        logic        divider_restart;
        logic        tick_irq_enable;
        logic        match_irq_enable;
        logic [15:0] prescale_divisor;
    } sca_mode_t;

    typedef struct packed {
        logic [29:0] unused;
        logic        tick_flag;
        logic        match_flag;
    } sca_flags_t;

    typedef enum logic [0:0] {
        CLR_IDLE = 1'b0,
        CLR_WAIT = 1'b1
    } sca_clr_state_t;

endpackage

// [hw/sca_prescaler.sv]
/*
 * slow clock enable generator and programmable prescaler.
 * assumes restart_i is a one-cycle pulse and divisor_i is already updated when it comes.
 */
`timescale 1ns/1ps
module sca_prescaler
    import sca_pkg::*;
#(
    parameter int unsigned SLOW_DIV_P = SLOW_DIV
) (
    input  wire logic        clk_sys_i,
    input  wire logic        rst_i,
    input  wire logic        restart_i,
    input  wire logic [15:0] divisor_i,
    output logic             slow_tick_o,
    output logic             inc_o
);
    localparam int unsigned SW = (SLOW_DIV_P > 1) ? $clog2(SLOW_DIV_P) : 1;
    localparam logic [SW-1:0] SLOW_LAST = SW'(SLOW_DIV_P - 1);

    logic [SW-1:0] slow_cnt_q;
    logic [15:0]   pre_cnt_q;

    // free running slow clock enable
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            slow_cnt_q  <= '0;
            slow_tick_o <= 1'b0;
        end else begin
            slow_cnt_q  <= (slow_cnt_q == SLOW_LAST) ? '0 : slow_cnt_q + SW'(1);
            slow_tick_o <= (slow_cnt_q == SLOW_LAST);
        end
    end

    // zero divisor minus one gives ffff, i.e. a period of 65536
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            pre_cnt_q <= PRE_RESET;
            inc_o     <= 1'b0;
        end else if (restart_i) begin
            pre_cnt_q <= divisor_i - 16'h1;
            inc_o     <= 1'b0;
        end else if (slow_tick_o) begin
            if (pre_cnt_q == 16'h0) begin
                pre_cnt_q <= divisor_i - 16'h1;
                inc_o     <= 1'b1;
            end else begin
                pre_cnt_q <= pre_cnt_q - 16'h1;
                inc_o     <= 1'b0;
            end
        end else begin
            inc_o <= 1'b0;
        end
    end

    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (rst_i);

    reload_value_a: assert property (
        (slow_tick_o && !restart_i && pre_cnt_q == 16'h0) |=> pre_cnt_q == $past(divisor_i) - 16'h1)
        else $error("prescaler did not reload from the divisor");
    restart_load_a: assert property (
        restart_i |=> (pre_cnt_q == $past(divisor_i) - 16'h1) && !inc_o)
        else $error("restart did not reload the prescaler");

endmodule // sca_prescaler

// [verification/sca_rtt_test.sv]
/*
 * self-checking bench of the seconds counter with alarm: register access, reset values,
 * prescaler periods, restart, read-cleared flags and interrupt gating, all over apb.
 * assumes sca_pkg and sca_rtt, with the slow clock shortened to one tick every 4 clocks.
 */
`timescale 1ns/1ps
`define CHK(act, exp) begin cmp_count++; if ((act) !== (exp)) begin fails++; \
    $display("MISMATCH t=%0t act=%h exp=%h", $time, (act), (exp)); end end

module sca_rtt_test;
    import sca_pkg::*;

    localparam int unsigned SDIV = 4;
    localparam int unsigned NPER = 4;

    typedef struct {
        logic [11:0] a;
        logic [31:0] d;
        logic [31:0] r;
        logic        e;
    } sca_row_t;

    logic              clk_sys_i;
    logic              rst_i;
    logic              psel_i;
    logic              penable_i;
    logic              pwrite_i;
    logic [APB_AW-1:0] paddr_i;
    logic [31:0]       pwdata_i;
    logic [31:0]       prdata_o;
    logic              pready_o;
    logic              pslverr_o;
    logic              irq_o;
    int                fails;
    int                cmp_count;
    logic [31:0]       va;
    logic [31:0]       vb;
    logic [31:0]       vc;
    logic              ve;
    sca_row_t          rows [4];

    sca_rtt #(.SLOW_DIV_P(SDIV)) uut (
        .clk_sys_i (clk_sys_i),
        .rst_i     (rst_i),
        .psel_i    (psel_i),
        .penable_i (penable_i),
        .pwrite_i  (pwrite_i),
        .paddr_i   (paddr_i),
        .pwdata_i  (pwdata_i),
        .prdata_o  (prdata_o),
        .pready_o  (pready_o),
        .pslverr_o (pslverr_o),
        .irq_o     (irq_o)
    );

    initial begin
        clk_sys_i = 1'b0;
        forever #50 clk_sys_i = ~clk_sys_i;
    end

    task automatic finish_test();
        if (fails == 0 && cmp_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // one apb transfer: setup after an edge, access held until pready is sampled high
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                        output logic [31:0] r, output logic e);
        int n;
        n = 0;
        @(posedge clk_sys_i);
        psel_i    <= 1'b1;
        penable_i <= 1'b0;
        pwrite_i  <= w;
        paddr_i   <= a;
        pwdata_i  <= d;
        @(posedge clk_sys_i);
        penable_i <= 1'b1;
        do begin
            @(posedge clk_sys_i);
            n++;
        end while (pready_o !== 1'b1 && n < 20);
        if (n >= 20) begin
            fails++;
            finish_test();
        end else begin
            r = prdata_o;
            e = pslverr_o;
            psel_i    <= 1'b0;
            penable_i <= 1'b0;
        end
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic        e;
        xfer(1'b1, a, d, r, e);
    endtask

    task automatic rd(input logic [11:0] a, output logic [31:0] r);
        logic e;
        xfer(1'b0, a, 32'h0000_0000, r, e);
    endtask

    task automatic do_reset();
        @(posedge clk_sys_i);
        rst_i <= 1'b1;
        repeat (3) @(posedge clk_sys_i);
        rst_i <= 1'b0;
    endtask

    initial begin
        rst_i     = 1'b1;
        psel_i    = 1'b0;
        penable_i = 1'b0;
        pwrite_i  = 1'b0;
        paddr_i   = '0;
        pwdata_i  = '0;
        fails     = 0;
        cmp_count = 0;
        // restart bit is a strobe; unmapped and unaligned places answer with an error
        rows[0] = '{a: OFS_MODE,  d: 32'h0007_0003, r: 32'h0003_0003, e: 1'b0};
        rows[1] = '{a: OFS_ALARM, d: 32'h1234_5678, r: 32'h1234_5678, e: 1'b0};
        rows[2] = '{a: 12'h010,   d: 32'h0000_0001, r: 32'h0000_0000, e: 1'b1};
        rows[3] = '{a: 12'h002,   d: 32'h0000_0001, r: 32'h0000_0000, e: 1'b1};
        do_reset();
        foreach (rows[i]) begin
            xfer(1'b1, rows[i].a, rows[i].d, va, ve);
            `CHK(ve, rows[i].e)
            xfer(1'b0, rows[i].a, 32'h0000_0000, va, ve);
            `CHK(va, rows[i].r)
            `CHK(ve, rows[i].e)
        end

        // second reset in mid-run brings back the documented reset values
        do_reset();
        `CHK(irq_o, 1'b0)
        rd(OFS_MODE, va);
        `CHK(va, 32'h0000_8000)
        rd(OFS_ALARM, va);
        `CHK(va, 32'hffff_ffff)
        rd(OFS_COUNT, va);
        `CHK(va, 32'h0000_0000)
        rd(OFS_FLAGS, va);
        `CHK(va, 32'h0000_0000)

        // restart zeroes the count at once
        wr(OFS_MODE, 32'h0004_0003);
        rd(OFS_COUNT, va);
        `CHK(va, 32'h0000_0000)

        // software rereads the count until two reads agree
        va = 32'h0000_0000;
        vb = 32'h0000_0001;
        for (int k = 0; k < 4 && vb !== va; k++) begin
            rd(OFS_COUNT, va);
            rd(OFS_COUNT, vb);
        end
        `CHK(vb, va)

        // reads spaced by exactly NPER periods see exactly NPER advances; divisors 1 to 3
        for (int d = 1; d <= 3; d++) begin
            wr(OFS_MODE, 32'h0004_0000 | d);
            rd(OFS_COUNT, va);
            repeat (NPER * SDIV * d - 4) @(posedge clk_sys_i);
            rd(OFS_COUNT, vb);
            `CHK(vb - va, 32'(NPER))
        end

        // divisor change alone: one more natural period, then the long divisor holds
        wr(OFS_MODE, 32'h0000_ffff);
        rd(OFS_COUNT, va);
        repeat (40) @(posedge clk_sys_i);
        rd(OFS_COUNT, vb);
        `CHK((vb - va) <= 32'h1, 1'b1)
        repeat (100) @(posedge clk_sys_i);
        rd(OFS_COUNT, vc);
        `CHK(vc, vb)

        // flags read back at once still set, gone two slow ticks later
        rd(OFS_FLAGS, va);
        `CHK(va, 32'h0000_0002)
        rd(OFS_FLAGS, va);
        `CHK(va, 32'h0000_0002)
        repeat (12) @(posedge clk_sys_i);
        rd(OFS_FLAGS, va);
        `CHK(va, 32'h0000_0000)

        // alarm at 5 matches when the count reaches 6
        wr(OFS_ALARM, 32'h0000_0005);
        wr(OFS_MODE, 32'h0004_0002);
        rd(OFS_FLAGS, va);
        repeat (20) @(posedge clk_sys_i);
        rd(OFS_FLAGS, va);
        `CHK(va[0], 1'b0)
        repeat (60) @(posedge clk_sys_i);
        `CHK(irq_o, 1'b0)
        wr(OFS_MODE, 32'h0001_0002);
        repeat (3) @(posedge clk_sys_i);
        `CHK(irq_o, 1'b1)
        rd(OFS_FLAGS, va);
        `CHK(va, 32'h0000_0003)
        `CHK(irq_o, 1'b1)
        repeat (12) @(posedge clk_sys_i);
        `CHK(irq_o, 1'b0)
        wr(OFS_MODE, 32'h0002_0002);
        repeat (12) @(posedge clk_sys_i);
        `CHK(irq_o, 1'b1)
        // handler masks the interrupt on entry while the tick flag still stands
        wr(OFS_MODE, 32'h0000_0002);
        repeat (2) @(posedge clk_sys_i);
        `CHK(irq_o, 1'b0)
        finish_test();
    end
endmodule // sca_rtt_test
